// ===== ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model #(
   parameter int PWRUP_CYC = 10000,
   parameter int RD_START_WAIT_CYC = 150
) (
   input wire logic pclk,
   output logic wr_port_clk,
   output logic wr_advance_gate,
   output logic wr_mask_n,
   output logic wr_mode_sel,
   output logic wr_line_step,
   output logic wr_addr_load,
   output logic wr_line_addr_in,
   output logic [fm_pkg::WORD_W-1:0] wr_word_in,
   output logic rd_port_clk,
   output logic rd_port_gate,
   output logic output_drive_gate,
   output logic rd_mode_sel,
   output logic rd_line_step,
   output logic rd_addr_load,
   output logic rd_line_addr_in
);
   import fm_pkg::*;
   initial begin
      // clocks and gates low from power-up
      {wr_port_clk, wr_advance_gate, wr_mask_n, wr_mode_sel, wr_line_step, wr_addr_load} = '0;
      {rd_port_clk, rd_port_gate, output_drive_gate, rd_mode_sel, rd_line_step, rd_addr_load} = '0;
      {wr_line_addr_in, rd_line_addr_in, wr_word_in} = '0;
   end
   ////////////////////////////////////////////////////////////////
   // c = {gate, mask_n, mode, step, load}; pins held 4 cycles around the edge
   task automatic wr_cyc(input logic [4:0] c, input logic a, input logic [WORD_W-1:0] d);
      {wr_advance_gate, wr_mask_n, wr_mode_sel, wr_line_step, wr_addr_load} <= c;
      wr_line_addr_in <= a;
      wr_word_in <= d;
      repeat (4) @(posedge pclk);
      wr_port_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      wr_port_clk <= 1'b0;
      // hold time over: never leave a stale copy on the lines
      wr_word_in <= ~d;
      wr_line_addr_in <= ~a;
      repeat (4) @(posedge pclk);
   endtask
   // c = {gate, output gate, mode, step, load}
   task automatic rd_cyc(input logic [4:0] c, input logic a);
      {rd_port_gate, output_drive_gate, rd_mode_sel, rd_line_step, rd_addr_load} <= c;
      rd_line_addr_in <= a;
      repeat (4) @(posedge pclk);
      rd_port_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_port_clk <= 1'b0;
      rd_line_addr_in <= ~a;
      repeat (4) @(posedge pclk);
   endtask
   task automatic start_wait(input logic p);
      repeat (p ? RD_START_WAIT_CYC : WR_START_WAIT_CYC) @(posedge pclk);
   endtask
   task automatic set_addr(input logic p, input logic [8:0] line);
      for (int i = 8; i >= 0; i--) begin
         if (p) rd_cyc(5'b00001, line[i]); // msb first, load high, mode low
         else wr_cyc(5'b00001, line[i], '0);
      end
      start_wait(p); // no serial access meanwhile
   endtask
   // one mode per cycle, chosen by {step, load}
   task automatic reset_cyc(input logic p, input logic [1:0] sl);
      if (p) rd_cyc({3'b001, sl}, 1'b0);
      else wr_cyc({3'b001, sl}, 1'b0, '0);
      start_wait(p);
   endtask
   task automatic power_up();
      repeat (PWRUP_CYC) @(posedge pclk);
      set_addr(1'b0, 9'h000);
      reset_cyc(1'b0, 2'b00); // dummy line committed
      set_addr(1'b1, 9'h000);
   endtask
endmodule

// ===== fm_pkg.sv
package fm_pkg;
   // memory geometry
   localparam int WORD_W = 12;
   localparam int LINE_WORDS = 768;
   localparam int LINES = 290;
   localparam int LINE_AW = 9;
   localparam int WORD_AW = 10;
   localparam int ARR_AW = 18;
   localparam int ARR_DEPTH = LINES * LINE_WORDS;
   localparam int BUF_AW = WORD_AW + 1;
   localparam int BUF_DEPTH = 2 * LINE_WORDS;
   localparam logic [WORD_AW-1:0] LAST_WORD = 10'h2FF;
   localparam logic [LINE_AW-1:0] LAST_LINE = 9'h121;
   localparam logic [ARR_AW-1:0] LINE_WORDS_A = 18'h00300;
   localparam logic [3:0] ADDR_LAST_BIT = 4'h8;
   // pin synchroniser widths
   localparam int WR_SYNC_W = 19;
   localparam int RD_SYNC_W = 7;
   // timing, clock is 50 MHz
   localparam int CLK_PERIOD_NS = 20;
   localparam int WR_START_WAIT_NS = 3000;
   localparam int WR_START_WAIT_CYC = (WR_START_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // apb register map
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [11:0] WR_POS_OFF = 12'h008;
   localparam logic [11:0] RD_POS_OFF = 12'h00C;
   localparam logic [11:0] ADDR_REG_OFF = 12'h010;
   localparam int CTRL_WR_ON_BIT = 0;
   localparam int CTRL_RD_ON_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_BANK_BIT = 1;
   localparam int STAT_WSHIFT_BIT = 2;
   localparam int STAT_RSHIFT_BIT = 3;
   localparam int POS_LINE_LSB = 16;
   // reset mode decode of {line_step, addr_load}
   typedef enum logic [1:0] {
      MODE_BASE = 2'b00,
      MODE_RESET = 2'b01,
      MODE_INC = 2'b10,
      MODE_JUMP = 2'b11
   } reset_mode_e;
   typedef enum logic [1:0] {
      COPY_IDLE = 2'b00,
      COPY_RUN = 2'b01,
      COPY_DRAIN = 2'b10
   } copy_state_e;
endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // a bit rises only once stages two and three agree, and falls as soon as they differ
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         dout <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         dout <= (s2 & s3) | (dout & ~(s2 ^ s3));
      end
   end
endmodule

// ===== sdp_mem.sv
`timescale 1ns/1ps
module sdp_mem #(
   parameter int W = 12,
   parameter int D = 768,
   parameter int AW = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [D];

   // array itself is not reset, contents are undefined until written
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ===== serial_field_line_memory.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module serial_field_line_memory (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wr_port_clk,
   input wire logic wr_advance_gate,
   input wire logic wr_mask_n,
   input wire logic wr_mode_sel,
   input wire logic wr_line_step,
   input wire logic wr_addr_load,
   input wire logic wr_line_addr_in,
   input wire logic [fm_pkg::WORD_W-1:0] wr_word_in,
   input wire logic rd_port_clk,
   input wire logic rd_port_gate,
   input wire logic output_drive_gate,
   input wire logic rd_mode_sel,
   input wire logic rd_line_step,
   input wire logic rd_addr_load,
   input wire logic rd_line_addr_in,
   output logic [fm_pkg::WORD_W-1:0] rd_word_out,
   output logic rd_word_oe_n
);
   import fm_pkg::*;

   function automatic logic [ARR_AW-1:0] arr_index(input logic [LINE_AW-1:0] l, input logic [WORD_AW-1:0] w);
      logic [LINE_AW-1:0] lc;
      lc = (l > LAST_LINE) ? LAST_LINE : l;
      return ARR_AW'(lc) * LINE_WORDS_A + ARR_AW'(w);
   endfunction

   function automatic logic [WORD_AW-1:0] word_step(input logic [WORD_AW-1:0] w);
      return (w == LAST_WORD) ? w : w + 10'h001;
   endfunction

   function automatic logic [LINE_AW-1:0] line_step(input logic [LINE_AW-1:0] l);
      return (l >= LAST_LINE) ? 9'h000 : l + 9'h001;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, data and strobes share the same stages: a rise takes four cycles, a fall three
   logic [WR_SYNC_W-1:0] wr_sync;
   logic [RD_SYNC_W-1:0] rd_sync;
   logic w_clk, w_gate, w_mask_n, w_mode, w_step, w_load, w_abit;
   logic [WORD_W-1:0] w_word;
   logic r_clk, r_gate, r_oe, r_mode, r_step, r_load, r_abit;

   pin_sync #(.W(WR_SYNC_W)) u_wr_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({wr_port_clk, wr_advance_gate, wr_mask_n, wr_mode_sel, wr_line_step,
            wr_addr_load, wr_line_addr_in, wr_word_in}),
      .dout(wr_sync)
   );

   pin_sync #(.W(RD_SYNC_W)) u_rd_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({rd_port_clk, rd_port_gate, output_drive_gate, rd_mode_sel, rd_line_step,
            rd_addr_load, rd_line_addr_in}),
      .dout(rd_sync)
   );

   assign {w_clk, w_gate, w_mask_n, w_mode, w_step, w_load, w_abit, w_word} = wr_sync;
   assign {r_clk, r_gate, r_oe, r_mode, r_step, r_load, r_abit} = rd_sync;

   logic w_clk_prev;
   logic r_clk_prev;
   logic [1:0] ctrl;
   logic wr_ev;
   logic rd_ev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_clk_prev <= 1'b0;
         r_clk_prev <= 1'b0;
      end else begin
         w_clk_prev <= w_clk;
         r_clk_prev <= r_clk;
      end
   end

   // each port sees only its own clock edges
   assign wr_ev = w_clk & ~w_clk_prev & ctrl[CTRL_WR_ON_BIT];
   assign rd_ev = r_clk & ~r_clk_prev & ctrl[CTRL_RD_ON_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // write port pointers
   logic [LINE_AW-1:0] wr_line;
   logic [WORD_AW-1:0] wr_word;
   logic [LINE_AW-1:0] wr_addr_reg;
   logic [LINE_AW-1:0] wr_shift;
   logic [3:0] wr_bits;
   logic wr_bank;
   logic xfer_ok;
   copy_state_e copy_state;

   assign xfer_ok = wr_ev & w_mode & (reset_mode_e'({w_step, w_load}) == MODE_BASE) & (copy_state == COPY_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_line <= '0;
         wr_word <= '0;
         wr_addr_reg <= '0;
         wr_shift <= '0;
         wr_bits <= '0;
      end else if (wr_ev) begin
         if (w_mode) begin
            wr_bits <= '0;
            unique case (reset_mode_e'({w_step, w_load}))
               MODE_BASE: begin
                  wr_word <= '0;
               end
               MODE_RESET: begin
                  wr_line <= '0;
                  wr_word <= '0;
               end
               MODE_INC: begin
                  wr_line <= line_step(wr_line);
                  wr_word <= '0;
               end
               MODE_JUMP: begin
                  wr_line <= wr_addr_reg;
                  wr_word <= '0;
               end
            endcase
         end else if (w_load) begin
            wr_shift <= {wr_shift[LINE_AW-2:0], w_abit};
            if (wr_bits == ADDR_LAST_BIT) begin
               wr_addr_reg <= {wr_shift[LINE_AW-2:0], w_abit};
               wr_line <= {wr_shift[LINE_AW-2:0], w_abit};
               wr_word <= '0;
               wr_bits <= '0;
            end else begin
               wr_bits <= wr_bits + 4'h1;
            end
         end else begin
            wr_bits <= '0;
            if (w_gate) begin
               wr_word <= word_step(wr_word);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two line registers; a transfer swaps them so copying never stalls writes
   logic buf_we;
   logic [LINE_WORDS-1:0] dirty [2];
   logic [WORD_AW-1:0] copy_word;
   logic [WORD_AW-1:0] copy_wword;
   logic copy_valid;
   logic copy_bank;
   logic [LINE_AW-1:0] copy_line;
   logic [WORD_W-1:0] buf_rdata;
   logic arr_we;
   logic [WORD_W-1:0] arr_rdata;

   assign buf_we = wr_ev & ~w_mode & ~w_load & w_gate & w_mask_n;

   sdp_mem #(.W(WORD_W), .D(BUF_DEPTH), .AW(BUF_AW)) u_line_buf (
      .pclk(pclk),
      .presetn(presetn),
      .we(buf_we),
      .waddr({wr_bank, wr_word}),
      .wdata(w_word),
      .raddr({copy_bank, copy_word}),
      .rdata(buf_rdata)
   );

   // masked words keep their old array contents, so only written words copy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dirty[0] <= '0;
         dirty[1] <= '0;
      end else begin
         if (copy_state == COPY_DRAIN) begin
            dirty[copy_bank] <= '0;
         end
         if (buf_we) begin
            dirty[wr_bank][wr_word] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_state <= COPY_IDLE;
         wr_bank <= 1'b0;
         copy_bank <= 1'b0;
         copy_line <= '0;
         copy_word <= '0;
      end else begin
         unique case (copy_state)
            COPY_IDLE: begin
               if (xfer_ok) begin
                  copy_state <= COPY_RUN;
                  copy_bank <= wr_bank;
                  copy_line <= wr_line;
                  copy_word <= '0;
                  wr_bank <= ~wr_bank;
               end
            end
            COPY_RUN: begin
               if (copy_word == LAST_WORD) begin
                  copy_state <= COPY_DRAIN;
               end else begin
                  copy_word <= copy_word + 10'h001;
               end
            end
            COPY_DRAIN: begin
               copy_state <= COPY_IDLE;
            end
            default: begin
               copy_state <= COPY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_valid <= 1'b0;
         copy_wword <= '0;
      end else begin
         copy_valid <= (copy_state == COPY_RUN);
         copy_wword <= copy_word;
      end
   end

   assign arr_we = copy_valid & dirty[copy_bank][copy_wword];

   ////////////////////////////////////////////////////////////////////////////
   // read port pointers
   logic [LINE_AW-1:0] rd_line;
   logic [WORD_AW-1:0] rd_word;
   logic [LINE_AW-1:0] rd_addr_reg;
   logic [LINE_AW-1:0] rd_shift;
   logic [3:0] rd_bits;
   logic rd_fetch;
   logic rd_fetch_d;

   sdp_mem #(.W(WORD_W), .D(ARR_DEPTH), .AW(ARR_AW)) u_field_array (
      .pclk(pclk),
      .presetn(presetn),
      .we(arr_we),
      .waddr(arr_index(copy_line, copy_wword)),
      .wdata(buf_rdata),
      .raddr(arr_index(rd_line, rd_word)),
      .rdata(arr_rdata)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_line <= '0;
         rd_word <= '0;
         rd_addr_reg <= '0;
         rd_shift <= '0;
         rd_bits <= '0;
      end else if (rd_ev) begin
         if (r_mode) begin
            rd_bits <= '0;
            unique case (reset_mode_e'({r_step, r_load}))
               MODE_BASE: begin
                  rd_word <= '0;
               end
               MODE_RESET: begin
                  rd_line <= '0;
                  rd_word <= '0;
               end
               MODE_INC: begin
                  rd_line <= line_step(rd_line);
                  rd_word <= '0;
               end
               MODE_JUMP: begin
                  rd_line <= rd_addr_reg;
                  rd_word <= '0;
               end
            endcase
         end else if (r_load) begin
            rd_shift <= {rd_shift[LINE_AW-2:0], r_abit};
            if (rd_bits == ADDR_LAST_BIT) begin
               rd_addr_reg <= {rd_shift[LINE_AW-2:0], r_abit};
               rd_line <= {rd_shift[LINE_AW-2:0], r_abit};
               rd_word <= '0;
               rd_bits <= '0;
            end else begin
               rd_bits <= rd_bits + 4'h1;
            end
         end else begin
            rd_bits <= '0;
            if (r_gate) begin
               rd_word <= word_step(rd_word);
            end
         end
      end
   end

   // the array read issued at the edge returns one pclk later
   assign rd_fetch = rd_ev & ~r_mode & ~r_load & r_gate & r_oe;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_fetch_d <= 1'b0;
         rd_word_out <= '0;
      end else begin
         rd_fetch_d <= rd_fetch;
         if (rd_fetch_d) begin
            rd_word_out <= arr_rdata;
         end
      end
   end

   // output enable follows its pin, not the read clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_word_oe_n <= 1'b1;
      end else begin
         rd_word_oe_n <= ~r_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state on every access
   logic apb_done;
   logic [31:0] next_prdata;
   logic next_slverr;

   assign apb_done = psel & penable & pready;

   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      unique case (paddr)
         CTRL_OFF: next_prdata[1:0] = ctrl;
         STATUS_OFF: begin
            next_prdata[STAT_BUSY_BIT] = (copy_state != COPY_IDLE);
            next_prdata[STAT_BANK_BIT] = wr_bank;
            next_prdata[STAT_WSHIFT_BIT] = (wr_bits != 4'h0);
            next_prdata[STAT_RSHIFT_BIT] = (rd_bits != 4'h0);
         end
         WR_POS_OFF: begin
            next_prdata[WORD_AW-1:0] = wr_word;
            next_prdata[POS_LINE_LSB +: LINE_AW] = wr_line;
         end
         RD_POS_OFF: begin
            next_prdata[WORD_AW-1:0] = rd_word;
            next_prdata[POS_LINE_LSB +: LINE_AW] = rd_line;
         end
         ADDR_REG_OFF: begin
            next_prdata[LINE_AW-1:0] = wr_addr_reg;
            next_prdata[POS_LINE_LSB +: LINE_AW] = rd_addr_reg;
         end
         default: next_slverr = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         prdata <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & next_slverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RESET;
      end else if (apb_done && pwrite && paddr == CTRL_OFF) begin
         ctrl <= pwdata[1:0];
      end
   end
endmodule

// ===== serial_field_line_memory_props.sv
`timescale 1ns/1ps
module serial_field_line_memory_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rd_port_gate,
   input wire logic output_drive_gate,
   input wire logic [fm_pkg::WORD_W-1:0] rd_word_out,
   input wire logic rd_word_oe_n
);
   import fm_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////
   AST_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not after one wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   AST_UNMAPPED: assert property (pready && paddr > ADDR_REG_OFF |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_MAPPED: assert property (pready && paddr[1:0] == 2'b00 && paddr <= ADDR_REG_OFF |-> !pslverr)
      else $error("mapped access refused");
   // oe lags its pin by five cycles turning on and four turning off, so six covers both
   AST_OE_ON: assert property (output_drive_gate [*6] |-> !rd_word_oe_n)
      else $error("outputs not driven");
   AST_OE_OFF: assert property (!output_drive_gate [*6] |-> rd_word_oe_n)
      else $error("outputs not released");
   AST_OUT_HOLD: assert property (!rd_port_gate [*8] |-> $stable(rd_word_out))
      else $error("read word changed with gate low");
   cover property (pready && pslverr);
   cover property (pready && !pslverr);
   cover property (rd_port_gate && $changed(rd_word_out));
endmodule
bind serial_field_line_memory serial_field_line_memory_props i_serial_field_line_memory_props (
   .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
   .rd_port_gate, .output_drive_gate, .rd_word_out, .rd_word_oe_n
);

// ===== serial_field_line_memory_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module serial_field_line_memory_tb;
   import fm_pkg::*;
   typedef struct {logic w; logic [11:0] a; logic [31:0] wd; logic [31:0] e; logic err;} row_s;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, rd_word_oe_n, err;
   logic [WORD_W-1:0] rd_word_out, wr_word_in;
   logic wr_port_clk, wr_advance_gate, wr_mask_n, wr_mode_sel, wr_line_step, wr_addr_load, wr_line_addr_in;
   logic rd_port_clk, rd_port_gate, output_drive_gate, rd_mode_sel, rd_line_step, rd_addr_load, rd_line_addr_in;
   int num_errors = 0, total_checks = 0;
   row_s rows[7] = '{'{1'b0, CTRL_OFF, 32'h0, 32'h3, 1'b0}, '{1'b1, CTRL_OFF, 32'h1, 32'h0, 1'b0},
      '{1'b0, CTRL_OFF, 32'h0, 32'h1, 1'b0}, '{1'b1, CTRL_OFF, 32'h3, 32'h0, 1'b0},
      '{1'b0, ADDR_REG_OFF, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
      '{1'b1, 12'h100, 32'h5, 32'h0, 1'b1}};
   // {read port, step, load, expected line}
   logic [11:0] modes[6] = '{12'h200, 12'h605, 12'h406, 12'hA00, 12'hE05, 12'hC06};
   serial_field_line_memory i_serial_field_line_memory (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .wr_port_clk, .wr_advance_gate, .wr_mask_n, .wr_mode_sel, .wr_line_step, .wr_addr_load,
      .wr_line_addr_in, .wr_word_in, .rd_port_clk, .rd_port_gate, .output_drive_gate, .rd_mode_sel,
      .rd_line_step, .rd_addr_load, .rd_line_addr_in, .rd_word_out, .rd_word_oe_n
   );
   ctrl_model i_ctrl_model (
      .pclk, .wr_port_clk, .wr_advance_gate, .wr_mask_n, .wr_mode_sel, .wr_line_step, .wr_addr_load,
      .wr_line_addr_in, .wr_word_in, .rd_port_clk, .rd_port_gate, .output_drive_gate, .rd_mode_sel,
      .rd_line_step, .rd_addr_load, .rd_line_addr_in
   );
   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // called just after an edge; idles one cycle after so calls never collide
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] d, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 20) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd, err);
      `CHK("register", e, rd)
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_OFF, 32'h0, rd, err);
         n++;
      end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 500);
      if (rd[STAT_BUSY_BIT] !== 1'b0) begin
         num_errors++;
         tally_and_finish();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge pclk);
      `CHK("oe_n in reset", 1'b1, rd_word_oe_n)
      `CHK("word in reset", 12'h000, rd_word_out)
      @(posedge pclk);
      presetn <= 1'b1;
      i_ctrl_model.power_up();
      wait_idle();
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].wd, rd, err);
         `CHK("apb data", rows[i].e, rd)
         `CHK("apb error", rows[i].err, err)
      end
      i_ctrl_model.set_addr(1'b0, 9'h005);
      i_ctrl_model.wr_cyc(5'b11000, 1'b0, 12'hA5C);
      i_ctrl_model.wr_cyc(5'b10000, 1'b0, 12'h111);
      i_ctrl_model.wr_cyc(5'b01000, 1'b0, 12'h222);
      i_ctrl_model.wr_cyc(5'b11000, 1'b0, 12'h3C7);
      chk_reg(WR_POS_OFF, 32'h0005_0003);
      i_ctrl_model.reset_cyc(1'b0, 2'b00);
      chk_reg(WR_POS_OFF, 32'h0005_0000);
      wait_idle();
      i_ctrl_model.set_addr(1'b1, 9'h005);
      chk_reg(ADDR_REG_OFF, 32'h0005_0005);
      i_ctrl_model.rd_cyc(5'b11000, 1'b0);
      `CHK("word 0", 12'hA5C, rd_word_out)
      i_ctrl_model.rd_cyc(5'b10000, 1'b0);
      `CHK("oe_n off", 1'b1, rd_word_oe_n)
      `CHK("held word", 12'hA5C, rd_word_out)
      i_ctrl_model.rd_cyc(5'b11000, 1'b0);
      `CHK("word 2", 12'h3C7, rd_word_out)
      i_ctrl_model.rd_cyc(5'b01000, 1'b0);
      `CHK("gate low word", 12'h3C7, rd_word_out)
      chk_reg(RD_POS_OFF, 32'h0005_0003);
      i_ctrl_model.reset_cyc(1'b1, 2'b00);
      chk_reg(RD_POS_OFF, 32'h0005_0000);
      i_ctrl_model.rd_cyc(5'b11000, 1'b0);
      `CHK("restart word", 12'hA5C, rd_word_out)
      foreach (modes[i]) begin
         i_ctrl_model.reset_cyc(modes[i][11], modes[i][10:9]);
         chk_reg(modes[i][11] ? RD_POS_OFF : WR_POS_OFF, {7'h00, modes[i][8:0], 16'h0000});
      end
      chk_reg(ADDR_REG_OFF, 32'h0005_0005);
      // masked writes and dark reads clock the pointers to the line end, where they hold
      repeat (LINE_WORDS + 2) i_ctrl_model.wr_cyc(5'b10000, 1'b0, 12'h5A5);
      repeat (LINE_WORDS + 2) i_ctrl_model.rd_cyc(5'b10000, 1'b0);
      chk_reg(WR_POS_OFF, {7'h00, 9'h006, 6'h00, LAST_WORD});
      chk_reg(RD_POS_OFF, {7'h00, 9'h006, 6'h00, LAST_WORD});
      // mid-run reset: outputs and pointers return, array contents stay
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("oe_n in mid reset", 1'b1, rd_word_oe_n)
      `CHK("word in mid reset", 12'h000, rd_word_out)
      presetn <= 1'b1;
      chk_reg(RD_POS_OFF, 32'h0000_0000);
      chk_reg(CTRL_OFF, 32'h0000_0003);
      // line not yet transferred, so the read still sees the old field
      i_ctrl_model.set_addr(1'b0, 9'h005);
      i_ctrl_model.wr_cyc(5'b11000, 1'b0, 12'h0F0);
      i_ctrl_model.set_addr(1'b1, 9'h005);
      i_ctrl_model.rd_cyc(5'b11000, 1'b0);
      `CHK("old word", 12'hA5C, rd_word_out)
      i_ctrl_model.reset_cyc(1'b0, 2'b00);
      wait_idle();
      i_ctrl_model.set_addr(1'b1, 9'h005);
      i_ctrl_model.rd_cyc(5'b11000, 1'b0);
      `CHK("new word", 12'h0F0, rd_word_out)
      tally_and_finish();
   end
endmodule
